// ==== include/wit_map.vh ====
// Register map, field positions and timing constants of the watchdog timer
`ifndef WIT_MAP_VH
`define WIT_MAP_VH
`define WIT_ADDR_W 16
`define WIT_ADDR_PERIOD 16'hFF42
`define WIT_ADDR_MODE 16'hFFF9
`define WIT_PERIOD_RST 8'h00
`define WIT_MODE_RST 8'h00
`define WIT_SEL_RST 3'h0
`define WIT_SEL_MSB 2
`define WIT_SEL_LSB 0
`define WIT_RUN_BIT 7
`define WIT_WDM_BIT 4
`define WIT_RVN_BIT 3
// Prescaler ahead of the counter: 2^12 main clocks per tick
`define WIT_PRE_W 12
// Counter of ticks: up to 2^8 ticks gives 2^20 clocks
`define WIT_CNT_W 9
`define WIT_SEL_MAX 3'h7
`define WIT_SEL_MAX_SHIFT 4'h8
`endif

// ==== hdl/wit_prescaler.v ====
// Free-running prescaler producing the counter tick enable
`timescale 1ns/100ps
module wit_prescaler (
  input wire clk_in,
  input wire reset_n_in,
  input wire run_in,
  output reg tick_out
);
`include "wit_map.vh"
  reg [`WIT_PRE_W-1:0] pre_q;
  // Never cleared by arming, so the first period may run short
  always @(posedge clk_in) begin
    if (!reset_n_in) begin
      pre_q <= {`WIT_PRE_W{1'b0}};
      tick_out <= 1'b0;
    end else if (run_in) begin
      pre_q <= pre_q + {{(`WIT_PRE_W-1){1'b0}}, 1'b1};
      tick_out <= &pre_q;
    end else begin
      tick_out <= 1'b0;
    end
  end
endmodule

// ==== hdl/wit_top.v ====
// Watchdog / interval timer with its two control registers
`timescale 1ns/100ps
module wit_top (
  input wire clk_in,
  input wire reset_n_in,
  input wire [15:0] addr_in,
  input wire wr_in,
  input wire rd_in,
  input wire [7:0] wdata_in,
  input wire halt_in,
  input wire stop_in,
  input wire interval_irq_mask_in,
  input wire interval_irq_priority_in,
  output reg [7:0] rdata_out,
  output reg interval_irq_out,
  output reg interval_irq_priority_out,
  output reg interval_irq_default_top_out,
  output reg nmi_req_out,
  output reg reset_req_out,
  output reg running_out
);
`include "wit_map.vh"
  reg [2:0] period_sel_q;
  reg [2:0] active_sel_q;
  reg run_q;
  reg watchdog_mode_sel_q;
  reg reset_vs_nmi_sel_q;
  reg [`WIT_CNT_W-1:0] cnt_q;
  reg [`WIT_CNT_W-1:0] cnt_d;
  reg [`WIT_CNT_W-1:0] limit;
  reg overflow;
  wire wr_period;
  wire wr_mode;
  wire arm;
  wire tick;
  wire count_en;

  // Whole-byte writes only; the bus carries no bit strobes
  assign wr_period = wr_in && (addr_in == `WIT_ADDR_PERIOD);
  assign wr_mode = wr_in && (addr_in == `WIT_ADDR_MODE);
  assign arm = wr_mode && wdata_in[`WIT_RUN_BIT];
  // HALT is ignored on purpose; only STOP freezes the timer
  assign count_en = run_q && !stop_in;

  wit_prescaler u_pre (
    .clk_in(clk_in),
    .reset_n_in(reset_n_in),
    .run_in(count_en),
    .tick_out(tick)
  );

  // Ticks of 2^12 clocks per period for each select code
  always @* begin
    if (active_sel_q == `WIT_SEL_MAX)
      limit = {`WIT_CNT_W{1'b0}} | ({{(`WIT_CNT_W-1){1'b0}}, 1'b1}
              << `WIT_SEL_MAX_SHIFT);
    else
      limit = {{(`WIT_CNT_W-1){1'b0}}, 1'b1} << active_sel_q;
  end

  always @* begin
    overflow = 1'b0;
    cnt_d = cnt_q;
    if (arm) begin
      cnt_d = {`WIT_CNT_W{1'b0}};
    end else if (count_en && tick) begin
      if (cnt_q + {{(`WIT_CNT_W-1){1'b0}}, 1'b1} >= limit) begin
        overflow = 1'b1;
        cnt_d = {`WIT_CNT_W{1'b0}};
      end else begin
        cnt_d = cnt_q + {{(`WIT_CNT_W-1){1'b0}}, 1'b1};
      end
    end
  end

  always @(posedge clk_in) begin
    if (!reset_n_in) begin
      period_sel_q <= `WIT_SEL_RST;
      active_sel_q <= `WIT_SEL_RST;
      run_q <= 1'b0;
      watchdog_mode_sel_q <= 1'b0;
      reset_vs_nmi_sel_q <= 1'b0;
      cnt_q <= {`WIT_CNT_W{1'b0}};
    end else begin
      cnt_q <= cnt_d;
      if (wr_period)
        period_sel_q <= wdata_in[`WIT_SEL_MSB:`WIT_SEL_LSB];
      // Period change is taken only when arming clears the counter, not on overflow
      if (arm) begin
        if (wr_period)
          active_sel_q <= wdata_in[`WIT_SEL_MSB:`WIT_SEL_LSB];
        else
          active_sel_q <= period_sel_q;
      end
      if (wr_mode) begin
        run_q <= run_q | wdata_in[`WIT_RUN_BIT];
        watchdog_mode_sel_q <= watchdog_mode_sel_q |
                               wdata_in[`WIT_WDM_BIT];
        reset_vs_nmi_sel_q <= reset_vs_nmi_sel_q |
                              wdata_in[`WIT_RVN_BIT];
      end
    end
  end

  // Outputs registered; one-clock pulses on overflow
  always @(posedge clk_in) begin
    if (!reset_n_in) begin
      rdata_out <= 8'h00;
      interval_irq_out <= 1'b0;
      interval_irq_priority_out <= 1'b0;
      interval_irq_default_top_out <= 1'b0;
      nmi_req_out <= 1'b0;
      reset_req_out <= 1'b0;
      running_out <= 1'b0;
    end else begin
      interval_irq_out <= overflow && !watchdog_mode_sel_q &&
                          !interval_irq_mask_in;
      interval_irq_priority_out <= interval_irq_priority_in;
      interval_irq_default_top_out <= 1'b1;
      nmi_req_out <= overflow && watchdog_mode_sel_q &&
                     !reset_vs_nmi_sel_q;
      reset_req_out <= overflow && watchdog_mode_sel_q &&
                       reset_vs_nmi_sel_q;
      running_out <= count_en;
      rdata_out <= 8'h00;
      if (rd_in && addr_in == `WIT_ADDR_PERIOD)
        rdata_out <= {5'h00, period_sel_q};
      else if (rd_in && addr_in == `WIT_ADDR_MODE)
        rdata_out <= {run_q, 2'h0, watchdog_mode_sel_q,
                      reset_vs_nmi_sel_q, 3'h0};
    end
  end
endmodule

// ==== dv/wit_properties.sv ====
// Port checker for the watchdog timer
`timescale 1ns/100ps
module wit_checker(input wire clk_in, input wire reset_n_in,
  input wire [15:0] addr_in, input wire wr_in, input wire rd_in,
  input wire [7:0] wdata_in, input wire stop_in,
  input wire interval_irq_mask_in, input wire [7:0] rdata_out,
  input wire interval_irq_out, input wire nmi_req_out,
  input wire reset_req_out, input wire running_out);
  wire any_w = interval_irq_out | nmi_req_out | reset_req_out;
  default clocking @(posedge clk_in); endclocking
  default disable iff (!reset_n_in);
  property p_one; any_w |=> !any_w; endproperty
  a_one: assert property (p_one) else $error("long pulse");
  property p_exc; $onehot0({interval_irq_out, nmi_req_out, reset_req_out});
  endproperty
  a_exc: assert property (p_exc) else $error("two requests");
  property p_stp; stop_in |=> !running_out; endproperty
  a_stp: assert property (p_stp) else $error("runs in stop");
  property p_arm; wr_in && addr_in == 16'hFFF9 && wdata_in[7] ##1 !stop_in
    |=> running_out; endproperty
  a_arm: assert property (p_arm) else $error("no start");
  property p_kep; running_out && !stop_in |=> running_out; endproperty
  a_kep: assert property (p_kep) else $error("run lost");
  property p_msk; interval_irq_mask_in [*2] |=> !interval_irq_out;
  endproperty
  a_msk: assert property (p_msk) else $error("masked irq");
  property p_rsv; rd_in && addr_in == 16'hFF42 |=> rdata_out[7:3] == 5'h00;
  endproperty
  a_rsv: assert property (p_rsv) else $error("reserved set");
  property p_rdz; !rd_in |=> rdata_out == 8'h00; endproperty
  a_rdz: assert property (p_rdz) else $error("stray data");
endmodule
bind wit_top wit_checker chk(.clk_in, .reset_n_in, .addr_in, .wr_in,
  .rd_in, .wdata_in, .stop_in, .interval_irq_mask_in, .rdata_out,
  .interval_irq_out, .nmi_req_out, .reset_req_out, .running_out);

// ==== dv/testbench.sv ====
// Self-checking bench for the watchdog timer
`timescale 1ns/100ps
module testbench;
  reg clk_in = 0, reset_n_in = 0, wr_in = 0, rd_in = 0, stop_in = 0;
  reg interval_irq_mask_in = 0, halt_in = 0, pri_in = 0;
  wire pri_o, top_o, run_o;
  reg [15:0] addr_in = 0;
  reg [7:0] wdata_in = 0, r = 0;
  wire [7:0] rdata_out;
  wire interval_irq_out, nmi_req_out, reset_req_out;
  wire [2:0] req = {reset_req_out, nmi_req_out, interval_irq_out};
  int failures = 0, checked = 0, n;
  wit_top dut(.clk_in, .reset_n_in, .addr_in, .wr_in, .rd_in, .wdata_in,
    .halt_in(halt_in), .stop_in, .interval_irq_mask_in,
    .interval_irq_priority_in(pri_in), .rdata_out, .interval_irq_out,
    .interval_irq_priority_out(pri_o), .interval_irq_default_top_out(top_o),
    .nmi_req_out, .reset_req_out, .running_out(run_o));
  initial forever #12.5 clk_in = ~clk_in;
  task chk(input string s, input [31:0] e, input [31:0] g);
    checked++;
    if (g !== e) begin
      failures++;
      $display("ERROR %s exp %0h got %0h", s, e, g);
    end
  endtask
  task wr(input [15:0] a, input [7:0] d);
    @(negedge clk_in) {addr_in, wdata_in, wr_in} = {a, d, 1'b1};
    @(negedge clk_in) wr_in = 0;
  endtask
  task rd(input [15:0] a, input [7:0] e);
    @(negedge clk_in) {addr_in, rd_in} = {a, 1'b1};
    @(negedge clk_in) rd_in = 0;
    chk("rdata", e, rdata_out);
    chk("prio", pri_in, pri_o);
    chk("top", 1, top_o);
  endtask
  // Counts cycles up to the next pulse of one request, or gives up at lim
  task wt(input int s, input int lim);
    n = 0;
    // HALT and priority wander at random; neither may move the period
    do begin
      @(negedge clk_in);
      {halt_in, pri_in} = $urandom;
      n++;
    end while (n < lim && req[s] !== 1'b1);
  endtask
  task final_report;
    if (failures == 0 && checked > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask
  initial begin
    #(25 * 95000) failures++;
    final_report;
  end
  initial begin
    r = $urandom(89);
    repeat (3) @(negedge clk_in);
    reset_n_in = 1;
    rd(16'hFF42, 8'h00);
    chk("idle", 0, run_o);
    wr(16'hFF42, r & 8'hF9);
    rd(16'hFF42, r & 8'h01);
    wr(16'hFFF9, 8'h80 | (r & 8'h67));
    rd(16'hFFF9, 8'h80);
    chk("run", 1, run_o);
    wt(0, 9000);
    wt(0, 9000);
    chk("period", 4096 << r[0], n);
    wr(16'hFF42, 8'h00);
    wr(16'hFFF9, 8'h80);
    wr(16'hFFF9, 8'h00);
    rd(16'hFFF9, 8'h80);
    wt(0, 9000);
    wt(0, 9000);
    chk("repeat", 4096, n);
    interval_irq_mask_in = 1;
    wt(0, 4200);
    chk("mask", 4200, n);
    interval_irq_mask_in = 0;
    wr(16'hFFF9, 8'h80);
    stop_in = 1;
    wt(0, 4200);
    chk("stop", 4200, n);
    chk("stop_run", 0, run_o);
    stop_in = 0;
    wt(0, 4200);
    chk("resume", 1, n < 4200);
    // Code 2 leaves room for a rearm despite the free prescaler
    wr(16'hFF42, 8'h02);
    wr(16'hFFF9, 8'h90);
    wr(16'hFFF9, 8'h00);
    rd(16'hFFF9, 8'h90);
    wt(1, 8000);
    chk("early", 8000, n);
    wr(16'hFFF9, 8'h80);
    wt(1, 8000);
    chk("rearm", 8000, n);
    wt(1, 9000);
    chk("nmi", 1, n < 9000);
    wr(16'hFFF9, 8'h98);
    rd(16'hFFF9, 8'h98);
    wt(2, 17000);
    chk("reset", 1, n < 17000);
    final_report;
  end
endmodule
